/* src/tpwl_pkg.sv */
// constants and types for the trickle power wakeup logic
package tpwl_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_WAKE_STATUS = 8'h00;
  localparam logic [7:0] OFS_WAKE_CLEAR  = 8'h04;
  localparam logic [7:0] OFS_WAKE_ENABLE = 8'h08;
  localparam logic [7:0] OFS_GPIO_STATUS = 8'h0c;
  localparam logic [7:0] OFS_GPIO_CLEAR  = 8'h10;
  localparam logic [7:0] OFS_GPIO_ENABLE = 8'h14;
  localparam logic [7:0] OFS_GPIO_DATA   = 8'h18;
  localparam logic [7:0] OFS_GPIO_DIR    = 8'h1c;
  localparam logic [7:0] OFS_PIN_CTRL    = 8'h20;
  localparam logic [7:0] OFS_PIN_STATUS  = 8'h24;

  // wake source bit positions
  localparam int unsigned SRC_RING  = 0;
  localparam int unsigned SRC_KBD   = 1;
  localparam int unsigned SRC_MOUSE = 2;
  localparam int unsigned SRC_KEY   = 3;
  localparam int unsigned SRC_TACH  = 4;
  localparam int unsigned SRC_W     = 5;

  // synchroniser vector positions, wake gpio inputs follow from I_GPIO
  localparam int unsigned I_SLOW = 5;
  localparam int unsigned I_MAIN = 6;
  localparam int unsigned I_HARD = 7;
  localparam int unsigned I_RET  = 8;
  localparam int unsigned I_NW   = 9;
  localparam int unsigned I_GPIO = 10;

  // pin status bit positions
  localparam int unsigned PS_MAIN = 0;
  localparam int unsigned PS_RET  = 1;
  localparam int unsigned PS_NW   = 2;
  localparam int unsigned PS_PME  = 3;
  localparam int unsigned PS_SLOW = 4;

  // internal substitute slow clock divider
  localparam int unsigned PCLK_HZ     = 100_000_000;
  localparam int unsigned SLOW_HZ     = 32768;
  localparam int unsigned INT_DIV     = PCLK_HZ / SLOW_HZ;
  localparam logic [11:0] INT_DIV_MAX = 12'(INT_DIV - 1);

  // led blink half period in slow ticks
  localparam int unsigned LED_HALF_TICKS_DEF = 16384;

  typedef enum logic [1:0] {
    LED_OFF     = 2'b00,
    LED_ON      = 2'b01,
    LED_BLINK   = 2'b10,
    LED_BLINK_N = 2'b11
  } tpwl_led_mode_t;

  typedef struct packed {
    logic           clk32_absent;
    tpwl_led_mode_t led_output_two_mode;
    tpwl_led_mode_t led_output_one_mode;
    logic           nw_data;
    logic           nw_dir;
    logic           ret_data;
    logic           ret_alt;
    logic           ret_odrain;
    logic           ret_inv;
    logic           ret_dir;
    logic           fan_inv;
    logic           fan_data;
  } tpwl_pin_ctrl_t;

  localparam tpwl_pin_ctrl_t PIN_CTRL_RST = '0;
  localparam logic [SRC_W-1:0] WAKE_RST   = '0;

endpackage : tpwl_pkg

/* src/tpwl_top.sv */
// trickle powered wakeup logic with apb register slave and pin control
//
// Local design decisions: the address map and the APB slave port.
module tpwl_top #(
  parameter int unsigned N_GPIO         = 8,
  parameter int unsigned LED_HALF_TICKS = tpwl_pkg::LED_HALF_TICKS_DEF
) (
  // clock and trickle power-on reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // supply state and slow clock
  input  wire logic              main_supply_good,
  input  wire logic              hard_reset_in,
  input  wire logic              slow_clk_in,
  // wake sources
  input  wire logic              ring_indicator_in,
  input  wire logic              keyboard_data_in,
  input  wire logic              mouse_data_in,
  input  wire logic              key_match_in,
  input  wire logic              fan_tach_in,
  input  wire logic [N_GPIO-1:0] gpio_wake_in,
  output logic      [N_GPIO-1:0] gpio_wake_out,
  output logic      [N_GPIO-1:0] gpio_wake_oe,
  // power event, open drain, and interrupt
  output logic                   power_event_out,
  output logic                   power_event_oe,
  output logic                   irq,
  // fan control pin
  output logic                   fan_control_out,
  output logic                   fan_control_oe,
  // retained configuration gpio
  input  wire logic              retained_config_gpio_in,
  input  wire logic              ret_alt_func_in,
  output logic                   retained_config_gpio_out,
  output logic                   retained_config_gpio_oe,
  // non wake gpio
  input  wire logic              non_wake_gpio_in,
  output logic                   non_wake_gpio_out,
  output logic                   non_wake_gpio_oe,
  // led pins
  output logic                   led_pin_one_out,
  output logic                   led_pin_one_oe,
  output logic                   led_pin_two_out,
  output logic                   led_pin_two_oe
);
  import tpwl_pkg::*;

  localparam int unsigned SW = I_GPIO + N_GPIO;

  // refuse gpio widths the register words cannot hold and led half periods the 16-bit counter cannot count
  generate
    if (N_GPIO < 1 || N_GPIO > 32) begin : g_bad_gpio
      $error("N_GPIO must be 1 to 32");
    end
    if (LED_HALF_TICKS < 1 || LED_HALF_TICKS > 65536) begin : g_bad_led
      $error("LED_HALF_TICKS must be 1 to 65536");
    end
  endgenerate

  localparam logic [15:0] LED_MAX = 16'(LED_HALF_TICKS - 1);

  function automatic logic rise(input logic prev, input logic cur);
    return ~prev & cur;
  endfunction : rise

  function automatic logic fall(input logic prev, input logic cur);
    return prev & ~cur;
  endfunction : fall

  function automatic logic is_mapped(input logic [7:0] a);
    return (a == OFS_WAKE_STATUS) || (a == OFS_WAKE_CLEAR) || (a == OFS_WAKE_ENABLE) ||
           (a == OFS_GPIO_STATUS) || (a == OFS_GPIO_CLEAR) || (a == OFS_GPIO_ENABLE) ||
           (a == OFS_GPIO_DATA)   || (a == OFS_GPIO_DIR)   || (a == OFS_PIN_CTRL)    ||
           (a == OFS_PIN_STATUS);
  endfunction : is_mapped

  function automatic logic led_level(input tpwl_led_mode_t m, input logic ph);
    logic v;
    v = 1'b0;
    unique case (m)
      LED_OFF:     v = 1'b0;
      LED_ON:      v = 1'b1;
      LED_BLINK:   v = ph;
      LED_BLINK_N: v = ~ph;
    endcase
    return v;
  endfunction : led_level

  logic [SW-1:0]     raw;
  logic [SW-1:0]     sync1_r;
  logic [SW-1:0]     sync2_r;
  logic [SW-1:0]     sync3_r;
  logic [SRC_W-1:0]  wake_st_r;
  logic [SRC_W-1:0]  wake_st_nxt;
  logic [SRC_W-1:0]  wake_en_r;
  logic [SRC_W-1:0]  wake_set;
  logic [SRC_W-1:0]  wake_clr;
  logic [N_GPIO-1:0] gpio_st_r;
  logic [N_GPIO-1:0] gpio_st_nxt;
  logic [N_GPIO-1:0] gpio_en_r;
  logic [N_GPIO-1:0] gpio_set;
  logic [N_GPIO-1:0] gpio_clr;
  logic [N_GPIO-1:0] gpio_dout_r;
  logic [N_GPIO-1:0] gpio_dir_r;
  tpwl_pin_ctrl_t    pin_ctrl_r;
  logic              main_ok;
  logic              slow_ok;
  logic              ext_tick;
  logic              int_tick;
  logic              slow_tick;
  logic [11:0]       int_div_r;
  logic [15:0]       led_cnt_r;
  logic              led_phase_r;
  logic              pme_nxt;
  logic              acc;
  logic              done;
  logic              wr;
  logic [31:0]       rdata_nxt;
  logic              fan_reset;
  logic              ret_lvl;
  logic              ret_pin;

  // every external level except ret_alt_func_in passes two flops before use, the third only feeds edge detection
  assign raw = {gpio_wake_in, non_wake_gpio_in, retained_config_gpio_in, hard_reset_in,
                main_supply_good, slow_clk_in, fan_tach_in, key_match_in,
                mouse_data_in, keyboard_data_in, ring_indicator_in};

  // input synchronisers, all on trickle power
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= '0;
      sync2_r <= '0;
      sync3_r <= '0;
    end else begin
      sync1_r <= raw;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  assign main_ok   = sync2_r[I_MAIN];
  // slow functions only have a clock if the external one runs or main power is up
  assign slow_ok   = ~pin_ctrl_r.clk32_absent | main_ok;
  assign ext_tick  = rise(sync3_r[I_SLOW], sync2_r[I_SLOW]);
  assign int_tick  = main_ok && (int_div_r == INT_DIV_MAX);
  assign slow_tick = pin_ctrl_r.clk32_absent ? int_tick : ext_tick;

  // substitute slow clock, runs only from the main-supply oscillator
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_div_r <= '0;
    end else if (!main_ok || int_tick) begin
      int_div_r <= '0;
    end else begin
      int_div_r <= int_div_r + 12'h001;
    end
  end

  // wake events: ring, keyboard and mouse on falling edge, slow-clocked sources gated
  always_comb begin
    wake_set            = '0;
    wake_set[SRC_RING]  = fall(sync3_r[SRC_RING], sync2_r[SRC_RING]);
    wake_set[SRC_KBD]   = fall(sync3_r[SRC_KBD], sync2_r[SRC_KBD]);
    wake_set[SRC_MOUSE] = fall(sync3_r[SRC_MOUSE], sync2_r[SRC_MOUSE]);
    wake_set[SRC_KEY]   = slow_ok & rise(sync3_r[SRC_KEY], sync2_r[SRC_KEY]);
    wake_set[SRC_TACH]  = slow_ok & rise(sync3_r[SRC_TACH], sync2_r[SRC_TACH]);
  end

  // any edge on a wake gpio is an event, the non-wake gpio is not in this vector
  assign gpio_set = sync2_r[SW-1:I_GPIO] ^ sync3_r[SW-1:I_GPIO];

  // apb: one wait state, write takes effect where pready is seen high, read data is sampled in the wait state before it
  assign acc  = psel & penable;
  assign done = acc & pready;
  assign wr   = done & pwrite;

  assign wake_clr = (wr && paddr == OFS_WAKE_CLEAR) ? pwdata[SRC_W-1:0] : '0;
  assign gpio_clr = (wr && paddr == OFS_GPIO_CLEAR) ? pwdata[N_GPIO-1:0] : '0;

  // a new event beats a clear in the same cycle
  assign wake_st_nxt = (wake_st_r & ~wake_clr) | wake_set;
  assign gpio_st_nxt = (gpio_st_r & ~gpio_clr) | gpio_set;

  // sticky status, reset only by the trickle power-on reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_st_r <= WAKE_RST;
      gpio_st_r <= '0;
    end else begin
      wake_st_r <= wake_st_nxt;
      gpio_st_r <= gpio_st_nxt;
    end
  end

  // main supply returning or a hard reset parks the fan pin low
  assign fan_reset = rise(sync3_r[I_MAIN], sync2_r[I_MAIN]) | sync2_r[I_HARD];

  // software-written configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_en_r   <= WAKE_RST;
      gpio_en_r   <= '0;
      gpio_dout_r <= '0;
      gpio_dir_r  <= '0;
      pin_ctrl_r  <= PIN_CTRL_RST;
    end else begin
      if (wr && paddr == OFS_WAKE_ENABLE) begin
        wake_en_r <= pwdata[SRC_W-1:0];
      end
      if (wr && paddr == OFS_GPIO_ENABLE) begin
        gpio_en_r <= pwdata[N_GPIO-1:0];
      end
      if (wr && paddr == OFS_GPIO_DATA) begin
        gpio_dout_r <= pwdata[N_GPIO-1:0];
      end
      if (wr && paddr == OFS_GPIO_DIR) begin
        gpio_dir_r <= pwdata[N_GPIO-1:0];
      end
      if (wr && paddr == OFS_PIN_CTRL) begin
        pin_ctrl_r <= tpwl_pin_ctrl_t'(pwdata[$bits(tpwl_pin_ctrl_t)-1:0]);
      end
      if (fan_reset) begin
        pin_ctrl_r.fan_data <= 1'b0;
        pin_ctrl_r.fan_inv  <= 1'b0;
      end
    end
  end

  // read multiplexer, unused bits read as zero
  always_comb begin
    rdata_nxt = '0;
    unique case (paddr)
      OFS_WAKE_STATUS: rdata_nxt[SRC_W-1:0]  = wake_st_r;
      OFS_WAKE_ENABLE: rdata_nxt[SRC_W-1:0]  = wake_en_r;
      OFS_GPIO_STATUS: rdata_nxt[N_GPIO-1:0] = gpio_st_r;
      OFS_GPIO_ENABLE: rdata_nxt[N_GPIO-1:0] = gpio_en_r;
      OFS_GPIO_DATA:   rdata_nxt[N_GPIO-1:0] = sync2_r[SW-1:I_GPIO];
      OFS_GPIO_DIR:    rdata_nxt[N_GPIO-1:0] = gpio_dir_r;
      OFS_PIN_CTRL:    rdata_nxt[$bits(tpwl_pin_ctrl_t)-1:0] = pin_ctrl_r;
      OFS_PIN_STATUS: begin
        rdata_nxt[PS_MAIN] = main_ok;
        rdata_nxt[PS_RET]  = sync2_r[I_RET];
        rdata_nxt[PS_NW]   = sync2_r[I_NW];
        rdata_nxt[PS_PME]  = power_event_oe;
        rdata_nxt[PS_SLOW] = slow_ok;
      end
      default:         rdata_nxt = '0;
    endcase
  end

  // apb answer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end else begin
      pready <= acc & ~pready;
      if (acc && !pready) begin
        prdata  <= pwrite ? 32'h0000_0000 : rdata_nxt;
        pslverr <= ~is_mapped(paddr);
      end else if (done) begin
        prdata  <= '0;
        pslverr <= 1'b0;
      end
    end
  end

  // led blink phase, advances only on slow ticks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      led_cnt_r   <= '0;
      led_phase_r <= 1'b0;
    end else if (slow_tick) begin
      if (led_cnt_r == LED_MAX) begin
        led_cnt_r   <= '0;
        led_phase_r <= ~led_phase_r;
      end else begin
        led_cnt_r <= led_cnt_r + 16'h0001;
      end
    end
  end

  // any latched and enabled event requests wakeup, whatever the main supply does
  assign pme_nxt = |(wake_st_r & wake_en_r) | |(gpio_st_r & gpio_en_r);

  // retained gpio: alternate function only while main power is up, config kept either way
  assign ret_pin = (pin_ctrl_r.ret_alt && main_ok) ? ret_alt_func_in : pin_ctrl_r.ret_data;
  assign ret_lvl = ret_pin ^ pin_ctrl_r.ret_inv;

  // registered pin drivers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_event_out          <= 1'b0;
      power_event_oe           <= 1'b0;
      irq                      <= 1'b0;
      gpio_wake_out            <= '0;
      gpio_wake_oe             <= '0;
      fan_control_out          <= 1'b0;
      fan_control_oe           <= 1'b0;
      retained_config_gpio_out <= 1'b0;
      retained_config_gpio_oe  <= 1'b0;
      non_wake_gpio_out        <= 1'b0;
      non_wake_gpio_oe         <= 1'b0;
      led_pin_one_out          <= 1'b0;
      led_pin_one_oe           <= 1'b0;
      led_pin_two_out          <= 1'b0;
      led_pin_two_oe           <= 1'b0;
    end else begin
      // open drain: only ever pulls low
      power_event_out <= 1'b0;
      power_event_oe  <= pme_nxt;
      irq             <= pme_nxt;
      // main-powered buffers release without main supply
      gpio_wake_out   <= gpio_dout_r;
      gpio_wake_oe    <= gpio_dir_r & {N_GPIO{main_ok}};
      // fan pin: inversion applies only with main supply
      fan_control_out <= main_ok ? (pin_ctrl_r.fan_data ^ pin_ctrl_r.fan_inv)
                                 : pin_ctrl_r.fan_data;
      fan_control_oe  <= 1'b1;
      // retained gpio honours push-pull or open drain
      retained_config_gpio_out <= pin_ctrl_r.ret_odrain ? 1'b0 : ret_lvl;
      retained_config_gpio_oe  <= main_ok & pin_ctrl_r.ret_dir &
                                  (~pin_ctrl_r.ret_odrain | ~ret_lvl);
      non_wake_gpio_out <= pin_ctrl_r.nw_data;
      non_wake_gpio_oe  <= main_ok & pin_ctrl_r.nw_dir;
      // led pins run from trickle power and keep driving
      led_pin_one_out <= led_level(pin_ctrl_r.led_output_one_mode, led_phase_r);
      led_pin_one_oe  <= 1'b1;
      led_pin_two_out <= led_level(pin_ctrl_r.led_output_two_mode, led_phase_r);
      led_pin_two_oe  <= 1'b1;
    end
  end

endmodule : tpwl_top

/* sim/tpwl_host_model.sv */
// host chipset side of the open drain power event line
module tpwl_host_model (
  // pin pair from the device
  input  wire logic power_event_out,
  input  wire logic power_event_oe,
  // level seen by the chipset, low means request
  output logic      pme_level
);
  timeunit 1ns;
  timeprecision 1ps;
  // board pull-up holds the released line high
  assign pme_level = power_event_oe ? power_event_out : 1'b1;
endmodule : tpwl_host_model

/* sim/tpwl_chk.sv */
// concurrent checks on the wakeup logic ports
module tpwl_chk #(
  parameter int unsigned N_GPIO = 8
) (
  // clock and reset
  input wire logic              pclk,
  input wire logic              presetn,
  // apb
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [7:0]        paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  // supply and clock
  input wire logic              main_supply_good,
  input wire logic              hard_reset_in,
  input wire logic              slow_clk_in,
  // wake sources
  input wire logic              ring_indicator_in,
  input wire logic              keyboard_data_in,
  input wire logic              mouse_data_in,
  input wire logic              key_match_in,
  input wire logic              fan_tach_in,
  input wire logic [N_GPIO-1:0] gpio_wake_in,
  input wire logic [N_GPIO-1:0] gpio_wake_out,
  input wire logic [N_GPIO-1:0] gpio_wake_oe,
  // power event and interrupt
  input wire logic              power_event_out,
  input wire logic              power_event_oe,
  input wire logic              irq,
  // pins
  input wire logic              fan_control_out,
  input wire logic              fan_control_oe,
  input wire logic              retained_config_gpio_in,
  input wire logic              ret_alt_func_in,
  input wire logic              retained_config_gpio_out,
  input wire logic              retained_config_gpio_oe,
  input wire logic              non_wake_gpio_in,
  input wire logic              non_wake_gpio_out,
  input wire logic              non_wake_gpio_oe,
  input wire logic              led_pin_one_out,
  input wire logic              led_pin_one_oe,
  input wire logic              led_pin_two_out,
  input wire logic              led_pin_two_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // power event pin and interrupt
  pme_open_drain_a: assert property (power_event_out == 1'b0) else $error("power event driven high");
  irq_follows_pme_a: assert property (irq == power_event_oe) else $error("irq differs from power event");
  pme_release_cause_a: assert property ($fell(power_event_oe) |-> $past(psel && penable && pwrite && pready, 2))
    else $error("power event released without a write");
  // apb timing
  apb_one_wait_a: assert property (psel && $rose(penable) |-> !pready ##1 pready) else $error("apb wait state wrong");
  ready_pulse_a: assert property (pready |=> !pready) else $error("pready longer than one cycle");
  err_with_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("read data outside answer");
  // pin behaviour with main supply off
  main_off_inputs_a: assert property ((!main_supply_good)[*5] |->
    gpio_wake_oe == '0 && !non_wake_gpio_oe && !retained_config_gpio_oe) else $error("pin driven without main");
  trickle_drivers_a: assert property ($past(presetn) |-> fan_control_oe && led_pin_one_oe && led_pin_two_oe)
    else $error("trickle pin not driven");

  // main scenarios reached
  cover property (pslverr);
  cover property ($fell(power_event_oe));
  cover property (!main_supply_good && power_event_oe);
endmodule : tpwl_chk

bind tpwl_top tpwl_chk #(.N_GPIO(N_GPIO)) u_tpwl_chk (.*);

/* sim/tb_top.sv */
// self-checking bench for the trickle power wakeup logic
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import tpwl_pkg::*;

  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, pme_level;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic main_supply_good, hard_reset_in, slow_clk_in, key_match_in, fan_tach_in;
  logic ring_indicator_in, keyboard_data_in, mouse_data_in, er, led_seen;
  logic [4:0] src;
  logic [7:0] gpio_wake_in, gpio_wake_out, gpio_wake_oe;
  logic power_event_out, power_event_oe, fan_control_out, fan_control_oe;
  logic retained_config_gpio_in, ret_alt_func_in, retained_config_gpio_out, retained_config_gpio_oe;
  logic non_wake_gpio_in, non_wake_gpio_out, non_wake_gpio_oe;
  logic led_pin_one_out, led_pin_one_oe, led_pin_two_out, led_pin_two_oe;
  int fail_count = 0;
  int total_checks = 0;

  // wake source vector: ring, kbd, mouse idle high, key, tach idle low
  assign {fan_tach_in, key_match_in, mouse_data_in, keyboard_data_in, ring_indicator_in} = src;

  tpwl_top #(.N_GPIO(8), .LED_HALF_TICKS(2)) u_tpwl_top (.*);
  tpwl_host_model u_tpwl_host_model (.power_event_out(power_event_out), .power_event_oe(power_event_oe),
                                     .pme_level(pme_level));

  // clock and a faster stand-in slow clock
  always #5 pclk = ~pclk;
  always begin
    repeat (8) @(posedge pclk);
    slow_clk_in <= ~slow_clk_in;
  end

  task tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish

  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // one apb transfer, result left in rd and er
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (n >= 20) begin
      check("apb answer", 0, 1);
      tally_and_finish();
    end
  endtask : apb

  task rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    check(what, rd, exp);
  endtask : rchk

  // bounded wait for the host line to reach a level
  task wait_pme(input logic exp);
    int n;
    n = 0;
    while (pme_level !== exp && n < 12) begin
      @(posedge pclk);
      n++;
    end
    check("host pme line", pme_level, exp);
    if (n >= 12) tally_and_finish();
  endtask : wait_pme

  // one edge pair on a wake source
  task fire(input int i);
    @(posedge pclk);
    src <= src ^ (5'h1 << i);
    repeat (6) @(posedge pclk);
    src <= src ^ (5'h1 << i);
    repeat (6) @(posedge pclk);
  endtask : fire

  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 8'h0; pwdata = 32'h0;
    main_supply_good = 0; hard_reset_in = 0; slow_clk_in = 0; src = 5'h07; gpio_wake_in = 8'h0;
    retained_config_gpio_in = 0; ret_alt_func_in = 0; non_wake_gpio_in = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    // reset values and unmapped access
    apb(1'b0, 8'h40, 32'h0);
    check("unmapped error", {31'h0, er}, 32'h1);
    check("unmapped data", rd, 32'h0);
    rchk(OFS_WAKE_ENABLE, 32'h0, "wake enable reset");
    rchk(OFS_PIN_CTRL, 32'h0, "pin ctrl reset");
    $display("test reset done");
    // every wake source with main on
    main_supply_good <= 1'b1;
    apb(1'b1, OFS_WAKE_ENABLE, 32'h1f);
    for (int i = 0; i < 5; i++) begin
      fire(i);
      rchk(OFS_WAKE_STATUS, 32'h1 << i, "wake status");
      wait_pme(1'b0);
      check("irq", irq, 1);
      apb(1'b1, OFS_WAKE_CLEAR, 32'h1 << i);
      wait_pme(1'b1);
    end
    $display("test sources done");
    // gpio wake and the non-wake gpio
    apb(1'b1, OFS_GPIO_ENABLE, 32'h08);
    @(posedge pclk);
    gpio_wake_in <= 8'h08;
    non_wake_gpio_in <= 1'b1;
    repeat (6) @(posedge pclk);
    rchk(OFS_GPIO_STATUS, 32'h08, "gpio status");
    rchk(OFS_WAKE_STATUS, 32'h0, "no wake from plain gpio");
    wait_pme(1'b0);
    apb(1'b1, OFS_GPIO_CLEAR, 32'h08);
    wait_pme(1'b1);
    $display("test gpio done");
    // pins across main supply loss: led on, retained out high, fan data and invert
    apb(1'b1, OFS_PIN_CTRL, 32'h247);
    repeat (4) @(posedge pclk);
    check("fan inverted", fan_control_out, 0);
    check("retained oe main on", retained_config_gpio_oe, 1);
    main_supply_good <= 1'b0;
    repeat (6) @(posedge pclk);
    check("fan plain", fan_control_out, 1);
    check("retained oe main off", retained_config_gpio_oe, 0);
    check("led one", {led_pin_one_oe, led_pin_one_out}, 32'h3);
    rchk(OFS_PIN_CTRL, 32'h247, "pin ctrl kept");
    rchk(OFS_WAKE_ENABLE, 32'h1f, "enable kept");
    fire(0);
    wait_pme(1'b0);
    apb(1'b1, OFS_WAKE_CLEAR, 32'h1);
    wait_pme(1'b1);
    // tach disabled before fan power goes: status only, no request
    apb(1'b1, OFS_WAKE_ENABLE, 32'h0f);
    fire(4);
    rchk(OFS_WAKE_STATUS, 32'h10, "tach latched");
    check("no request from tach", pme_level, 1);
    apb(1'b1, OFS_WAKE_CLEAR, 32'h10);
    // no slow clock and no main: key match ignored
    apb(1'b1, OFS_PIN_CTRL, 32'h2247);
    fire(3);
    rchk(OFS_WAKE_STATUS, 32'h0, "key without slow clock");
    $display("test trickle done");
    // main return and hard reset clear fan data and invert
    main_supply_good <= 1'b1;
    repeat (6) @(posedge pclk);
    rchk(OFS_PIN_CTRL, 32'h2244, "fan cleared by main");
    apb(1'b1, OFS_PIN_CTRL, 32'h2247);
    @(posedge pclk);
    hard_reset_in <= 1'b1;
    repeat (6) @(posedge pclk);
    hard_reset_in <= 1'b0;
    rchk(OFS_PIN_CTRL, 32'h2244, "fan cleared by hard reset");
    check("fan low", {fan_control_oe, fan_control_out}, 32'h2);
    $display("test fan done");
    // wake gpio drivers, pin status, led blink, open drain and alternate function, then main loss
    apb(1'b1, OFS_GPIO_DIR, 32'h0f);
    apb(1'b1, OFS_GPIO_DATA, 32'ha5);
    apb(1'b1, OFS_PIN_CTRL, 32'h1794);
    repeat (2) @(posedge pclk);
    check("wake gpio oe main on", gpio_wake_oe, 32'h0f);
    check("wake gpio out", gpio_wake_out, 32'ha5);
    check("non-wake pin", {non_wake_gpio_oe, non_wake_gpio_out}, 32'h3);
    check("retained open drain", {retained_config_gpio_oe, retained_config_gpio_out}, 32'h2);
    check("led blink pair", led_pin_one_out ^ led_pin_two_out, 32'h1);
    led_seen = led_pin_two_out;
    repeat (32) @(posedge pclk);
    check("led blink", led_pin_two_out, {31'h0, ~led_seen});
    rchk(OFS_GPIO_DATA, 32'h08, "wake gpio pins");
    rchk(OFS_GPIO_DIR, 32'h0f, "wake gpio dir");
    rchk(OFS_PIN_STATUS, 32'h15, "pin status");
    ret_alt_func_in <= 1'b1;
    apb(1'b1, OFS_PIN_CTRL, 32'h17a4);
    repeat (2) @(posedge pclk);
    check("retained alt", {retained_config_gpio_oe, retained_config_gpio_out}, 32'h3);
    main_supply_good <= 1'b0;
    repeat (4) @(posedge pclk);
    check("wake gpio oe main off", gpio_wake_oe, 32'h0);
    check("non-wake oe main off", non_wake_gpio_oe, 32'h0);
    check("retained plain gpio", retained_config_gpio_out, 32'h0);
    $display("test pins done");
    tally_and_finish();
  end
endmodule : tb_top
